// >>> core/vci_pkg.sv
package vci_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CODE_LEN = 8'h04;
    localparam logic [7:0] ADDR_CODE_LOW = 8'h08;
    localparam logic [7:0] ADDR_CODE_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_WARN_TIME = 8'h10;
    localparam logic [7:0] ADDR_SHUTDOWN_MIN = 8'h14;
    localparam logic [7:0] ADDR_REARM_DELAY = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // ------------------------------------------------------------------
    // reset values and legal ranges
    // ------------------------------------------------------------------
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [3:0] RST_CODE_LEN = 4'h5;
    localparam logic [3:0] CODE_LEN_MIN = 4'h1;
    localparam logic [3:0] CODE_LEN_MAX = 4'h8;
    // code halves are kept as four bcd digits each
    localparam logic [15:0] RST_CODE_LOW = 16'h2345;
    localparam logic [15:0] RST_CODE_HIGH = 16'h0001;
    localparam logic [9:0] RST_WARN_S = 10'h001;
    localparam logic [9:0] WARN_S_MIN = 10'h001;
    localparam logic [9:0] WARN_S_MAX = 10'h28f;
    localparam logic [9:0] RST_SHUTDOWN_S = 10'h00a;
    localparam logic [9:0] SHUTDOWN_S_MIN = 10'h00a;
    localparam logic [9:0] SHUTDOWN_S_MAX = 10'h03c;
    localparam logic [9:0] RST_REARM_S = 10'h00a;
    localparam logic [9:0] REARM_S_MIN = 10'h001;
    localparam logic [9:0] REARM_S_MAX = 10'h28f;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES_DFLT = CLOCK_HZ / MS_PER_S;
    localparam logic [9:0] LAST_MS_OF_S = 10'h3e7;
    localparam logic [10:0] SHORT_BEEP_MS = 11'h064;
    localparam logic [10:0] LONG_BEEP_MS = 11'h5dc;
    localparam logic [10:0] SLOW_FLASH_HALF_MS = 11'h1f4;
    localparam logic [4:0] DEBOUNCE_MS = 5'h14;

    // ------------------------------------------------------------------
    // input pin positions in the filtered vector
    // ------------------------------------------------------------------
    localparam int NUM_DIGITS = 10;
    localparam int PIN_CLEAR = 10;
    localparam int PIN_BRAKE = 11;
    localparam int PIN_KEY_RUN = 12;
    localparam int PIN_ENGINE = 13;
    localparam int PIN_SPEED = 14;
    localparam int NUM_PINS = 15;

    // ------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ARMED = 6'h02,
        ST_ACCEPTED = 6'h04,
        ST_WARN = 6'h08,
        ST_SHUTDOWN = 6'h10,
        ST_REARM = 6'h20
    } vci_state_type;

endpackage : vci_pkg

// >>> core/vci_tick.sv
`timescale 1ns/1ps
module vci_tick #(
    parameter int unsigned CYCLES = 20000
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    output logic o_tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } vci_tick_type;

    vci_tick_type q;
    vci_tick_type d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == LAST) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;

endmodule : vci_tick

// >>> core/vci_debounce.sv
`timescale 1ns/1ps
module vci_debounce (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_pin,
    input wire logic i_ms_tick,
    output logic o_level,
    output logic o_press
);
    typedef struct packed {
        logic [2:0] sync;
        logic stable;
        logic [4:0] cnt;
        logic press;
    } vci_deb_type;

    vci_deb_type q;
    vci_deb_type d;

    always_comb begin
        d = q;
        d.sync = {q.sync[1:0], i_pin};
        d.press = 1'b0;
        // sync[0] is only ever read by sync[1]
        if ((q.sync[1] == q.sync[2]) && (q.sync[2] != q.stable)) begin
            if (i_ms_tick) begin
                if (q.cnt == vci_pkg::DEBOUNCE_MS) begin
                    d.stable = q.sync[2];
                    d.press = q.sync[2];
                    d.cnt = '0;
                end else begin
                    d.cnt = q.cnt + 5'h01;
                end
            end
        end else begin
            d.cnt = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.stable;
    assign o_press = q.press;

endmodule : vci_debounce

// >>> core/vci_immobilizer.sv
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module vci_immobilizer #(
    parameter int unsigned MS_CYCLES = vci_pkg::MS_CYCLES_DFLT
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [9:0] i_digit_sw,
    input wire logic i_clear_sw,
    input wire logic i_park_brake,
    input wire logic i_key_run,
    input wire logic i_engine_running,
    input wire logic i_speed_above_limit,
    output logic o_stop_lamp,
    output logic o_alarm,
    output logic o_engine_kill
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        vci_pkg::vci_state_type state;
        logic enable;
        logic [3:0] code_len;
        logic [15:0] code_low;
        logic [15:0] code_high;
        logic [9:0] warn_s;
        logic [9:0] shutdown_s;
        logic [9:0] rearm_s;
        logic [31:0] entry;
        logic [3:0] ndig;
        logic locked;
        logic [10:0] fb_ms;
        logic [9:0] ms_of_s;
        logic [9:0] secs;
        logic [10:0] flash_ms;
        logic flash_on;
        logic lamp;
        logic alarm;
        logic kill;
        logic [31:0] prdata;
    } vci_core_type;

    vci_core_type q;
    vci_core_type d;

    // ------------------------------------------------------------
    // input filtering and time base
    // ------------------------------------------------------------
    logic ms_tick;
    logic [vci_pkg::NUM_PINS-1:0] pins;
    logic [vci_pkg::NUM_PINS-1:0] lvl;
    logic [vci_pkg::NUM_PINS-1:0] press;

    vci_tick #(
        .CYCLES(MS_CYCLES)
    ) u_ms_tick (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .o_tick(ms_tick)
    );

    assign pins = {i_speed_above_limit, i_engine_running, i_key_run,
                   i_park_brake, i_clear_sw, i_digit_sw};

    genvar gp;
    generate
        for (gp = 0; gp < vci_pkg::NUM_PINS; gp++) begin : g_pin
            vci_debounce u_deb (
                .i_clock(i_clock),
                .i_rst_b(i_rst_b),
                .i_pin(pins[gp]),
                .i_ms_tick(ms_tick),
                .o_level(lvl[gp]),
                .o_press(press[gp])
            );
        end
    endgenerate

    logic brake;
    logic key_run;
    logic engine_on;
    logic speeding;
    assign brake = lvl[vci_pkg::PIN_BRAKE];
    assign key_run = lvl[vci_pkg::PIN_KEY_RUN];
    assign engine_on = lvl[vci_pkg::PIN_ENGINE];
    assign speeding = lvl[vci_pkg::PIN_SPEED];

    // ------------------------------------------------------------
    // digit capture and code compare
    // ------------------------------------------------------------
    logic digit_hit;
    logic [3:0] digit;
    logic [31:0] entry_shift;
    logic [31:0] code_full;
    logic [7:0] nib_ok;
    logic code_match;

    always_comb begin
        digit_hit = 1'b0;
        digit = 4'h0;
        // two digits in one cycle: the lower one wins, the other is lost
        for (int i = vci_pkg::NUM_DIGITS - 1; i >= 0; i--) begin
            if (press[i]) begin
                digit_hit = 1'b1;
                digit = i[3:0];
            end
        end
    end

    // newest digit enters at the right, so the first one ends leftmost
    assign entry_shift = {q.entry[27:0], digit};
    assign code_full = {q.code_high, q.code_low};

    genvar gn;
    generate
        for (gn = 0; gn < 8; gn++) begin : g_nib
            assign nib_ok[gn] = (4'(gn) >= q.code_len) ||
                (entry_shift[4*gn +: 4] == code_full[4*gn +: 4]);
        end
    endgenerate
    assign code_match = &nib_ok;

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic addr_hit;
    always_comb begin
        case (i_paddr)
            vci_pkg::ADDR_CTRL, vci_pkg::ADDR_CODE_LEN,
            vci_pkg::ADDR_CODE_LOW, vci_pkg::ADDR_CODE_HIGH,
            vci_pkg::ADDR_WARN_TIME, vci_pkg::ADDR_SHUTDOWN_MIN,
            vci_pkg::ADDR_REARM_DELAY, vci_pkg::ADDR_STATUS: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // range limits are enforced on write so the timers never see
    // a value outside the legal window
    function automatic logic [9:0] vci_clamp(input logic [31:0] v,
                                             input logic [9:0] lo,
                                             input logic [9:0] hi);
        logic [9:0] r;
        if (v < 32'(lo)) begin
            r = lo;
        end else if (v > 32'(hi)) begin
            r = hi;
        end else begin
            r = v[9:0];
        end
        return r;
    endfunction : vci_clamp

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic entry_open;
    logic correct;
    logic wrong;
    logic sec_tick;
    logic [3:0] ndig_inc;

    always_comb begin
        d = q;
        sec_tick = 1'b0;
        correct = 1'b0;
        wrong = 1'b0;
        ndig_inc = q.ndig + 4'h1;

        // register writes take effect at the access edge
        if (i_psel && i_penable && i_pwrite) begin
            case (i_paddr)
                vci_pkg::ADDR_CTRL: begin
                    d.enable = i_pwdata[0];
                end
                vci_pkg::ADDR_CODE_LEN: begin
                    d.code_len = 4'(vci_clamp(i_pwdata,
                        10'(vci_pkg::CODE_LEN_MIN),
                        10'(vci_pkg::CODE_LEN_MAX)));
                end
                vci_pkg::ADDR_CODE_LOW: begin
                    d.code_low = i_pwdata[15:0];
                end
                vci_pkg::ADDR_CODE_HIGH: begin
                    d.code_high = i_pwdata[15:0];
                end
                vci_pkg::ADDR_WARN_TIME: begin
                    d.warn_s = vci_clamp(i_pwdata, vci_pkg::WARN_S_MIN,
                                         vci_pkg::WARN_S_MAX);
                end
                vci_pkg::ADDR_SHUTDOWN_MIN: begin
                    d.shutdown_s = vci_clamp(i_pwdata,
                        vci_pkg::SHUTDOWN_S_MIN,
                        vci_pkg::SHUTDOWN_S_MAX);
                end
                vci_pkg::ADDR_REARM_DELAY: begin
                    d.rearm_s = vci_clamp(i_pwdata, vci_pkg::REARM_S_MIN,
                                          vci_pkg::REARM_S_MAX);
                end
                default: begin
                end
            endcase
        end

        // read data is captured in the setup cycle
        if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                vci_pkg::ADDR_CTRL: d.prdata = {31'h0, q.enable};
                vci_pkg::ADDR_CODE_LEN: d.prdata = {28'h0, q.code_len};
                vci_pkg::ADDR_CODE_LOW: d.prdata = {16'h0, q.code_low};
                vci_pkg::ADDR_CODE_HIGH: d.prdata = {16'h0, q.code_high};
                vci_pkg::ADDR_WARN_TIME: d.prdata = {22'h0, q.warn_s};
                vci_pkg::ADDR_SHUTDOWN_MIN: d.prdata = {22'h0, q.shutdown_s};
                vci_pkg::ADDR_REARM_DELAY: d.prdata = {22'h0, q.rearm_s};
                vci_pkg::ADDR_STATUS: begin
                    d.prdata = {19'h0, q.kill, q.ndig, q.locked,
                                1'b0, q.state};
                end
                default: d.prdata = 32'h0;
            endcase
        end

        // time base: seconds and the slow flash
        if (ms_tick) begin
            if (q.ms_of_s == vci_pkg::LAST_MS_OF_S) begin
                d.ms_of_s = '0;
                sec_tick = 1'b1;
            end else begin
                d.ms_of_s = q.ms_of_s + 10'h001;
            end
            if (q.fb_ms != '0) begin
                d.fb_ms = q.fb_ms - 11'h001;
            end
            if (q.flash_ms == vci_pkg::SLOW_FLASH_HALF_MS) begin
                d.flash_ms = '0;
                d.flash_on = !q.flash_on;
            end else begin
                d.flash_ms = q.flash_ms + 11'h001;
            end
        end
        if (sec_tick && (q.secs != '1)) begin
            d.secs = q.secs + 10'h001;
        end

        // code entry
        entry_open = (q.state == vci_pkg::ST_ARMED) ||
                     (q.state == vci_pkg::ST_WARN);
        if (entry_open && !q.locked && digit_hit) begin
            d.entry = entry_shift;
            d.ndig = ndig_inc;
            if (ndig_inc == q.code_len) begin
                correct = code_match;
                wrong = !code_match;
                d.entry = '0;
                d.ndig = '0;
            end
        end
        if (correct) begin
            d.fb_ms = vci_pkg::SHORT_BEEP_MS;
        end
        if (wrong) begin
            // after a wrong code only a clear with the brake set, or a return to idle, reopens
            d.locked = 1'b1;
            d.fb_ms = vci_pkg::LONG_BEEP_MS;
        end
        if (press[vci_pkg::PIN_CLEAR] && brake) begin
            d.entry = '0;
            d.ndig = '0;
            // a wrong code completing in the same cycle keeps the lock
            d.locked = wrong;
        end // no branch for the brake-released case

        // main sequence
        case (q.state)
            vci_pkg::ST_IDLE: begin
                if (key_run && engine_on) begin
                    d.state = brake ? vci_pkg::ST_ARMED
                                    : vci_pkg::ST_WARN;
                end
            end
            vci_pkg::ST_ARMED: begin
                if (correct) begin
                    d.state = vci_pkg::ST_ACCEPTED;
                end else if (!brake || speeding) begin
                    d.state = vci_pkg::ST_WARN;
                end
            end
            vci_pkg::ST_ACCEPTED: begin
                if (press[vci_pkg::PIN_BRAKE]) begin
                    d.state = vci_pkg::ST_ARMED;
                end
            end
            vci_pkg::ST_WARN: begin
                if (correct) begin
                    d.state = vci_pkg::ST_ACCEPTED;
                end else if (brake && !speeding) begin
                    d.state = vci_pkg::ST_ARMED;
                end else if (q.secs >= q.warn_s) begin
                    d.state = vci_pkg::ST_SHUTDOWN;
                end
            end
            vci_pkg::ST_SHUTDOWN: begin
                if (q.secs >= q.shutdown_s) begin
                    d.state = vci_pkg::ST_REARM;
                end
            end
            vci_pkg::ST_REARM: begin
                if (q.secs >= q.rearm_s) begin
                    d.state = vci_pkg::ST_IDLE;
                end
            end
            default: begin
                d.state = vci_pkg::ST_IDLE;
            end
        endcase

        // key leaving run drops to idle, but a shutdown and the rearm
        // delay that follows it still run their full time
        if (!key_run && (q.state != vci_pkg::ST_SHUTDOWN) &&
            (q.state != vci_pkg::ST_REARM)) begin
            d.state = vci_pkg::ST_IDLE;
        end
        if (!q.enable) begin
            d.state = vci_pkg::ST_IDLE;
            d.fb_ms = '0;
        end
        if ((d.state == vci_pkg::ST_IDLE) ||
            (d.state == vci_pkg::ST_ACCEPTED) ||
            (d.state != q.state && d.state == vci_pkg::ST_ARMED &&
             q.state == vci_pkg::ST_ACCEPTED)) begin
            d.entry = '0;
            d.ndig = '0;
            d.locked = 1'b0;
        end

        // every state change restarts its timers
        if (d.state != q.state) begin
            d.secs = '0;
            d.ms_of_s = '0;
            d.flash_ms = '0;
            d.flash_on = 1'b1;
        end

        // outputs
        d.kill = (d.state == vci_pkg::ST_SHUTDOWN);
        d.alarm = (d.fb_ms != '0) ||
                  (d.state == vci_pkg::ST_WARN);
        d.lamp = (d.fb_ms != '0) || d.kill ||
                 ((d.state == vci_pkg::ST_WARN) && d.flash_on);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            q <= '0;
            q.state <= vci_pkg::ST_IDLE;
            q.enable <= vci_pkg::RST_ENABLE;
            q.code_len <= vci_pkg::RST_CODE_LEN;
            q.code_low <= vci_pkg::RST_CODE_LOW;
            q.code_high <= vci_pkg::RST_CODE_HIGH;
            q.warn_s <= vci_pkg::RST_WARN_S;
            q.shutdown_s <= vci_pkg::RST_SHUTDOWN_S;
            q.rearm_s <= vci_pkg::RST_REARM_S;
        end else begin
            q <= d;
        end
    end

    assign o_prdata = q.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_hit;
    assign o_stop_lamp = q.lamp;
    assign o_alarm = q.alarm;
    assign o_engine_kill = q.kill;

endmodule : vci_immobilizer

// >>> dv/vci_props.sv
`timescale 1ns/1ps
module vci_props #(
    parameter int unsigned MS_CYCLES = 20000
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_stop_lamp,
    input wire logic o_alarm,
    input wire logic o_engine_kill
);
    localparam int BEEP_MIN = 99 * MS_CYCLES;
    localparam int WARN_MIN = 999 * MS_CYCLES;
    localparam int KILL_MIN = 9999 * MS_CYCLES;
    int al_q;
    int kl_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    // run lengths; on a falling edge they still hold the finished run
    always_ff @(posedge i_clock) begin
        al_q <= (i_rst_b && o_alarm) ? al_q + 1 : 0;
        kl_q <= (i_rst_b && o_engine_kill) ? kl_q + 1 : 0;
    end
    a_ready_const: assert property (i_psel |-> o_pready)
        else $error("pready low");
    a_unmapped_err: assert property (i_psel && i_penable |->
        o_pslverr == ((i_paddr > 8'h1c) || (i_paddr[1:0] != 2'h0)))
        else $error("pslverr wrong");
    a_beep_lamp: assert property ($rose(o_alarm) |-> o_stop_lamp)
        else $error("alarm without lamp");
    a_beep_length: assert property (
        $fell(o_alarm) |-> al_q >= BEEP_MIN) else $error("beep short");
    a_kill_after_warn: assert property (
        $rose(o_engine_kill) |-> al_q >= WARN_MIN) else $error("early kill");
    a_kill_holds: assert property (
        $rose(o_engine_kill) |=> o_engine_kill [*8]) else $error("kill blip");
    a_kill_lamp: assert property (o_engine_kill |-> o_stop_lamp)
        else $error("kill without lamp");
    a_kill_min_time: assert property (
        $fell(o_engine_kill) |-> kl_q >= KILL_MIN) else $error("kill short");
endmodule : vci_props
bind vci_immobilizer vci_props #(.MS_CYCLES(MS_CYCLES)) u_props (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_stop_lamp(o_stop_lamp), .o_alarm(o_alarm),
    .o_engine_kill(o_engine_kill));

// >>> dv/vci_vehicle.sv
`timescale 1ns/1ps
module vci_vehicle #(
    parameter int MS = 4
) (
    input wire logic i_clock,
    input wire logic i_engine_kill,
    output logic [9:0] o_digit_sw,
    output logic o_clear_sw,
    output logic o_park_brake,
    output logic o_key_run,
    output logic o_engine_running,
    output logic o_speed_above_limit
);
    initial begin
        o_digit_sw = 10'h000;
        o_clear_sw = 1'b0;
        o_park_brake = 1'b1;
        o_key_run = 1'b0;
        o_engine_running = 1'b0;
        o_speed_above_limit = 1'b0;
    end
    // the relay cuts the ignition feed; engine runs again once freed
    always @(posedge i_clock) begin
        o_engine_running <= o_key_run && !i_engine_kill;
    end
    // position 10 is clear; held well past the filter time
    task automatic press(input int d);
        @(posedge i_clock);
        {o_clear_sw, o_digit_sw} <= 11'h001 << d;
        repeat (40 * MS) @(posedge i_clock);
        {o_clear_sw, o_digit_sw} <= 11'h000;
        repeat (40 * MS) @(posedge i_clock);
    endtask : press
    task automatic set(input logic b, input logic k, input logic s);
        @(posedge i_clock);
        o_park_brake <= b;
        o_key_run <= k;
        o_speed_above_limit <= s;
        repeat (40 * MS) @(posedge i_clock);
    endtask : set
endmodule : vci_vehicle

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int MS = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic [9:0] dsw;
    logic rdy, err, e, lamp, alarm, kill, clr, brk, key, eng, spd;
    int fail_count = 0;
    int compares = 0;
    int n;
    int dg[8];
    logic [7:0] ca[4] = '{8'h04, 8'h10, 8'h14, 8'h14};
    logic [31:0] cw[4] = '{32'h9, 32'h0, 32'h3d, 32'h5};
    logic [31:0] ce[4] = '{32'h8, 32'h1, 32'h3c, 32'ha};
    logic [31:0] rv[7] = '{32'h0, 32'h5, 32'h2345, 32'h1, 32'h1, 32'ha,
        32'ha};
    always #25 clk = ~clk;
    vci_immobilizer #(.MS_CYCLES(MS)) dut (.i_clock(clk), .i_rst_b(rst_b),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .i_digit_sw(dsw), .i_clear_sw(clr), .i_park_brake(brk),
        .i_key_run(key), .i_engine_running(eng),
        .i_speed_above_limit(spd), .o_stop_lamp(lamp), .o_alarm(alarm),
        .o_engine_kill(kill));
    vci_vehicle #(.MS(MS)) car (.i_clock(clk), .i_engine_kill(kill),
        .o_digit_sw(dsw), .o_clear_sw(clr), .o_park_brake(brk),
        .o_key_run(key), .o_engine_running(eng),
        .o_speed_above_limit(spd));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic test_done();
        $display("fails %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // bounded so a stuck output cannot hang the run
    task automatic wt(ref logic s, input logic v, output int c);
        c = 0;
        while (s !== v && c < 12000 * MS) begin
            @(posedge clk);
            c++;
        end
        if (s !== v) begin
            fail_count++;
            $display("ERROR %0t wait limit reached", $time);
        end
    endtask : wt
    function automatic logic [31:0] in_ms(int c, int lo, int hi);
        return 32'(c >= lo * MS && c <= hi * MS);
    endfunction : in_ms
    function automatic logic [31:0] half(int s);
        return {16'h0, 4'(dg[s]), 4'(dg[s+1]), 4'(dg[s+2]), 4'(dg[s+3])};
    endfunction : half
    task automatic beep(input int ms);
        wt(alarm, 1'b1, n);
        chk(32'(lamp), 32'h1);
        wt(alarm, 1'b0, n);
        chk(in_ms(n, ms - 1, ms + 1), 32'h1);
    endtask : beep
    task automatic code(input int off);
        foreach (dg[i]) car.press((dg[i] + off) % 10);
    endtask : code
    initial begin
        repeat (98000) @(posedge clk);
        fail_count++;
        $display("ERROR %0t timeout", $time);
        test_done();
    end
    initial begin
        void'($urandom(32'h635ec20d));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rv[i]) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, rv[i]);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        foreach (ca[i]) begin
            apb(1'b1, ca[i], cw[i]);
            apb(1'b0, ca[i], 32'h0);
            chk(rd, ce[i]);
        end
        foreach (dg[i]) dg[i] = $urandom_range(9);
        dg[0] = 0;
        apb(1'b1, 8'h0c, half(0));
        apb(1'b1, 8'h08, half(4));
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, half(0));
        apb(1'b1, 8'h04, 32'h8);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        car.set(1'b1, 1'b1, 1'b0);
        chk(32'(alarm), 32'h0);
        fork
            beep(100);
            code(0);
        join
        car.set(1'b0, 1'b1, 1'b0);
        car.press(10);
        repeat (200 * MS) @(posedge clk);
        chk(32'({alarm, kill}), 32'h0);
        car.set(1'b1, 1'b1, 1'b0);
        fork
            wt(alarm, 1'b1, n);
            car.set(1'b0, 1'b1, 1'b0);
        join
        chk(32'(lamp), 32'h1);
        repeat (650 * MS) @(posedge clk);
        chk(32'({alarm, lamp}), 32'h2);
        car.set(1'b1, 1'b1, 1'b0);
        chk(32'({alarm, lamp, kill}), 32'h0);
        car.set(1'b1, 1'b1, 1'b1);
        chk(32'(alarm), 32'h1);
        // a warning cut shorter than a beep would trip the beep checker
        repeat (100 * MS) @(posedge clk);
        car.set(1'b0, 1'b1, 1'b0);
        car.set(1'b1, 1'b1, 1'b0);
        chk(32'(alarm), 32'h0);
        fork
            beep(1500);
            code(1);
        join
        chk(32'(kill), 32'h0);
        car.press(10);
        chk(32'(alarm), 32'h0);
        fork
            beep(100);
            code(0);
        join
        car.set(1'b1, 1'b0, 1'b0);
        car.set(1'b1, 1'b1, 1'b0);
        fork
            wt(alarm, 1'b1, n);
            car.set(1'b0, 1'b1, 1'b0);
        join
        chk(32'(alarm), 32'h1);
        wt(kill, 1'b1, n);
        chk(in_ms(n, 900, 1100), 32'h1);
        car.set(1'b1, 1'b1, 1'b0);
        wt(kill, 1'b0, n);
        chk(in_ms(n, 9800, 11100), 32'h1);
        repeat (1500 * MS) @(posedge clk);
        chk(32'({alarm, kill}), 32'h0);
        // after the delay the start sequence has run again: armed, clean
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h2);
        test_done();
    end
endmodule : testbench
